// File: gpcde_regs.vh
// Register offsets, reset values and decode constants for the port C/D/E slice
`ifndef GPCDE_REGS_VH
`define GPCDE_REGS_VH

// I/O-space offsets of the port registers
`define GPCDE_OFS_E_INPUT     6'h01
`define GPCDE_OFS_E_DIR       6'h02
`define GPCDE_OFS_E_DRIVE     6'h03
`define GPCDE_OFS_D_INPUT     6'h10
`define GPCDE_OFS_D_DIR       6'h11
`define GPCDE_OFS_D_DRIVE     6'h12
`define GPCDE_OFS_C_INPUT     6'h13
`define GPCDE_OFS_C_DIR       6'h14
`define GPCDE_OFS_C_DRIVE     6'h15

// Data-space view of the I/O window
`define GPCDE_DATA_IO_BASE    16'h0020
`define GPCDE_DATA_EXT_BASE   16'h0060

// Reset values
`define GPCDE_RST_DRIVE       8'h00
`define GPCDE_RST_DIR         8'h00

`endif

// File: gpcde_pin_sync.v
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/100ps
module gpcde_pin_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             rst_n,
    // Asynchronous pins in, settled level out
    input  wire [WIDTH-1:0] pinAsync,
    output wire [WIDTH-1:0] pinLevel
);

    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;
    reg [WIDTH-1:0] stage3_q;
    reg [WIDTH-1:0] level_q;

    // ==========================================================
    // Per-bit sampling chain
    // ==========================================================
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gBit
            // Stage 1 feeds only stage 2; level moves once 2 and 3 agree
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage1_q[i] <= 1'b0;
                    stage2_q[i] <= 1'b0;
                    stage3_q[i] <= 1'b0;
                    level_q[i]  <= 1'b0;
                end else begin
                    stage1_q[i] <= pinAsync[i];
                    stage2_q[i] <= stage1_q[i];
                    stage3_q[i] <= stage2_q[i];
                    if (stage2_q[i] == stage3_q[i]) begin
                        level_q[i] <= stage3_q[i];
                    end
                end
            end
        end
    endgenerate

    assign pinLevel = level_q;

endmodule // gpcde_pin_sync

// File: gpcde_port_regs.v
// Port C, D and E drive, direction and input-sample registers
//
// Contract
// - I/O offsets also decoded at data plus 0x20
// - Extended region from 0x60 only via data space
// - Drive registers C/D/E at 0x15/0x12/0x03, reset zero
// - Direction registers at 0x14/0x11/0x02, reset inputs
// - Input sample registers read-only, writes ignored
// - Register bit n maps to pin n
// - Compatibility mode: port C drives low outputs
// - Compatibility low drive works without clock
// - Input with drive bit set pulls up unless disabled
`timescale 1ns/100ps
`include "gpcde_regs.vh"
// Timing, counted in ref_clk edges:
//   a write strobe sampled at edge k updates its register at edge k
//   the pad controls follow one edge later, so pads move at edge k+1
//   pull-ups take the same one-edge path as drive and direction
//   a read strobe at edge k gives read data and dataHit for one cycle
//   a pad change reaches a sample read after four edges: three sampling
//   flops plus the stage that waits for the last two to agree
//   sample reads ignore direction, so a driven pin reads its own level
//   the compat strap drives port C low at once, with no edge needed
// Limits:
//   a short write and a data write in one cycle: the short one wins and
//   the data write is lost; the core is not expected to issue both
//   unmapped offsets read zero and do not claim the data access
//   the global pull-up off input is taken as a same-clock level
//   the strap is meant as a static level; dropping it at run time frees
//   port C only after the synchroniser has followed, a few edges later
module gpcde_port_regs (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    // Short I/O instruction access (IN/OUT style)
    input  wire        ioRead,
    input  wire        ioWrite,
    input  wire [5:0]  ioAddr,
    input  wire [7:0]  ioWrData,
    output reg  [7:0]  ioRdData,
    // Data-space load/store access
    input  wire        dataRead,
    input  wire        dataWrite,
    input  wire [15:0] dataAddr,
    input  wire [7:0]  dataWrData,
    output reg  [7:0]  dataRdData,
    output reg         dataHit,
    // Mode and global controls
    input  wire        compatMode,
    input  wire        globalPullupOff,
    // Pin levels from the pads
    input  wire [7:0]  portCPins,
    input  wire [7:0]  portDPins,
    input  wire [7:0]  portEPins,
    // Per-pin controls to the pad logic
    output reg  [7:0]  portCDrive,
    output reg  [7:0]  portCOutEn,
    output reg  [7:0]  portCPullup,
    output reg  [7:0]  portDDrive,
    output reg  [7:0]  portDOutEn,
    output reg  [7:0]  portDPullup,
    output reg  [7:0]  portEDrive,
    output reg  [7:0]  portEOutEn,
    output reg  [7:0]  portEPullup
);

    // ==========================================================
    // Storage
    // ==========================================================
    reg  [7:0] portCDriveValue_q;
    reg  [7:0] portCDirection_q;
    reg  [7:0] portDDriveValue_q;
    reg  [7:0] portDDirection_q;
    reg  [7:0] portEDriveValue_q;
    reg  [7:0] portEDirection_q;
    reg        compatSync1_q;
    reg        compatSync2_q;
    reg        compatSync3_q;
    reg        compat_q;

    wire [7:0] portCSample;
    wire [7:0] portDSample;
    wire [7:0] portESample;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    gpcde_pin_sync #(.WIDTH(24)) uPinSync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .pinAsync ({portEPins, portDPins, portCPins}),
        .pinLevel ({portESample, portDSample, portCSample})
    );

    // Mode strap is a pin: three flops, change once stages 2 and 3 agree
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            compatSync1_q <= 1'b0;
            compatSync2_q <= 1'b0;
            compatSync3_q <= 1'b0;
            compat_q      <= 1'b0;
        end else begin
            compatSync1_q <= compatMode;
            compatSync2_q <= compatSync1_q;
            compatSync3_q <= compatSync2_q;
            if (compatSync2_q == compatSync3_q) begin
                compat_q <= compatSync3_q;
            end
        end
    end

    // ==========================================================
    // Address decode
    // ==========================================================
    // Data window 0x20..0x5F mirrors the short I/O space
    wire        dataInIo  = (dataAddr >= `GPCDE_DATA_IO_BASE) &&
                            (dataAddr <  `GPCDE_DATA_EXT_BASE);
    wire [15:0] dataIoOfs = dataAddr - `GPCDE_DATA_IO_BASE;
    // A short access names at most 0x3F, so extended space is unreachable
    wire        wrEn      = ioWrite | (dataWrite & dataInIo);
    wire [5:0]  wrAddr    = ioWrite ? ioAddr : dataIoOfs[5:0];
    wire [7:0]  wrData    = ioWrite ? ioWrData : dataWrData;

    // Read mux shared by both access paths
    function [8:0] readReg;
        input [5:0] ofs;
        begin
            if (ofs == `GPCDE_OFS_C_DRIVE) begin
                readReg = {1'b1, portCDriveValue_q};
            end else if (ofs == `GPCDE_OFS_C_DIR) begin
                readReg = {1'b1, portCDirection_q};
            end else if (ofs == `GPCDE_OFS_C_INPUT) begin
                readReg = {1'b1, portCSample};
            end else if (ofs == `GPCDE_OFS_D_DRIVE) begin
                readReg = {1'b1, portDDriveValue_q};
            end else if (ofs == `GPCDE_OFS_D_DIR) begin
                readReg = {1'b1, portDDirection_q};
            end else if (ofs == `GPCDE_OFS_D_INPUT) begin
                readReg = {1'b1, portDSample};
            end else if (ofs == `GPCDE_OFS_E_DRIVE) begin
                readReg = {1'b1, portEDriveValue_q};
            end else if (ofs == `GPCDE_OFS_E_DIR) begin
                readReg = {1'b1, portEDirection_q};
            end else if (ofs == `GPCDE_OFS_E_INPUT) begin
                readReg = {1'b1, portESample};
            end else begin
                readReg = 9'h000;
            end
        end
    endfunction

    wire [8:0] ioRead9   = readReg(ioAddr);
    wire [8:0] dataRead9 = readReg(dataIoOfs[5:0]);

    // ==========================================================
    // Writable registers
    // ==========================================================
    // Sample offsets have no storage; a write there matches no branch
    // Port C: still writable in compat mode, but the pads ignore it then
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            portCDriveValue_q <= `GPCDE_RST_DRIVE;
            portCDirection_q  <= `GPCDE_RST_DIR;
        end else if (wrEn) begin
            if (wrAddr == `GPCDE_OFS_C_DRIVE) begin
                portCDriveValue_q <= wrData;
            end else if (wrAddr == `GPCDE_OFS_C_DIR) begin
                portCDirection_q <= wrData;
            end
        end
    end

    // Port D: same decode, its own offsets
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            portDDriveValue_q <= `GPCDE_RST_DRIVE;
            portDDirection_q  <= `GPCDE_RST_DIR;
        end else if (wrEn) begin
            if (wrAddr == `GPCDE_OFS_D_DRIVE) begin
                portDDriveValue_q <= wrData;
            end else if (wrAddr == `GPCDE_OFS_D_DIR) begin
                portDDirection_q <= wrData;
            end
        end
    end

    // Port E: same decode, its own offsets
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            portEDriveValue_q <= `GPCDE_RST_DRIVE;
            portEDirection_q  <= `GPCDE_RST_DIR;
        end else if (wrEn) begin
            if (wrAddr == `GPCDE_OFS_E_DRIVE) begin
                portEDriveValue_q <= wrData;
            end else if (wrAddr == `GPCDE_OFS_E_DIR) begin
                portEDirection_q <= wrData;
            end
        end
    end

    // ==========================================================
    // Read data, registered
    // ==========================================================
    // Short reads: unmapped offsets return zero
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ioRdData <= 8'h00;
        end else begin
            ioRdData <= ioRead ? ioRead9[7:0] : 8'h00;
        end
    end

    // Data reads outside the mirrored window return zero
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataRdData <= 8'h00;
        end else begin
            dataRdData <= (dataRead & dataInIo) ? dataRead9[7:0] : 8'h00;
        end
    end

    // Claim flag: a data access landed on a mapped register
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataHit <= 1'b0;
        end else begin
            dataHit <= (dataRead | dataWrite) & dataInIo & dataRead9[8];
        end
    end

    // ==========================================================
    // Pull-up requests
    // ==========================================================
    // An input pin with its drive bit set asks for a pull-up; the global
    // off control overrides all three ports at once
    wire [7:0] portCPullWant = ~portCDirection_q & portCDriveValue_q &
                               {8{~globalPullupOff}};
    wire [7:0] portDPullWant = ~portDDirection_q & portDDriveValue_q &
                               {8{~globalPullupOff}};
    wire [7:0] portEPullWant = ~portEDirection_q & portEDriveValue_q &
                               {8{~globalPullupOff}};

    // ==========================================================
    // Port C pin controls
    // ==========================================================
    // The strap presets these flops asynchronously, so the legacy low
    // drive reaches the pads even while no clock runs; the synchronised
    // copy keeps the state steady for a few edges after the strap drops
    always @(posedge ref_clk or negedge rst_n or posedge compatMode) begin
        if (compatMode) begin
            portCDrive  <= 8'h00;
            portCOutEn  <= 8'hFF;
            portCPullup <= 8'h00;
        end else if (!rst_n) begin
            portCDrive  <= 8'h00;
            portCOutEn  <= 8'h00;
            portCPullup <= 8'h00;
        end else if (compat_q) begin
            portCDrive  <= 8'h00;
            portCOutEn  <= 8'hFF;
            portCPullup <= 8'h00;
        end else begin
            portCDrive  <= portCDriveValue_q;
            portCOutEn  <= portCDirection_q;
            portCPullup <= portCPullWant;
        end
    end

    // ==========================================================
    // Port D and E pin controls, one flop per output bit
    // ==========================================================
    genvar n;
    generate
        for (n = 0; n < 8; n = n + 1) begin : gPinDE
            // Bit n of the port D registers steers pin n only
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    portDDrive[n]  <= 1'b0;
                    portDOutEn[n]  <= 1'b0;
                    portDPullup[n] <= 1'b0;
                end else begin
                    portDDrive[n]  <= portDDriveValue_q[n];
                    portDOutEn[n]  <= portDDirection_q[n];
                    portDPullup[n] <= portDPullWant[n];
                end
            end
            // Same for port E
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    portEDrive[n]  <= 1'b0;
                    portEOutEn[n]  <= 1'b0;
                    portEPullup[n] <= 1'b0;
                end else begin
                    portEDrive[n]  <= portEDriveValue_q[n];
                    portEOutEn[n]  <= portEDirection_q[n];
                    portEPullup[n] <= portEPullWant[n];
                end
            end
        end
    endgenerate

endmodule // gpcde_port_regs

// File: gpcde_port_regs_props.sv
// Checker for the port C/D/E register slice, bound to its top module
`timescale 1ns/100ps
module gpcde_port_regs_props (
    // Clock, reset and access
    input wire        ref_clk,
    input wire        rst_n,
    input wire        ioWrite,
    input wire [5:0]  ioAddr,
    input wire [7:0]  ioWrData,
    input wire        dataRead,
    input wire        dataWrite,
    input wire [15:0] dataAddr,
    input wire [7:0]  dataWrData,
    input wire [7:0]  dataRdData,
    input wire        dataHit,
    // Modes and pad controls
    input wire        compatMode,
    input wire        globalPullupOff,
    input wire [7:0]  portCDrive,
    input wire [7:0]  portCOutEn,
    input wire [7:0]  portCPullup,
    input wire [7:0]  portDDrive,
    input wire [7:0]  portDOutEn,
    input wire [7:0]  portDPullup,
    input wire [7:0]  portEDrive,
    input wire [7:0]  portEPullup
);
    // ==========
    // Assertions, all in the one clock domain
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    hit_needs_access_a: assert property (
        !(dataRead || dataWrite) |=> !dataHit) else $error("data hit without access");
    ext_region_a: assert property (
        (dataRead || dataWrite) && dataAddr >= 16'h0060 |=> !dataHit && dataRdData == 8'h00)
        else $error("extended region claimed");
    pullup_off_a: assert property (
        globalPullupOff [*3] |-> (portCPullup | portDPullup | portEPullup) == 8'h00)
        else $error("pull-up while globally off");
    no_pull_out_a: assert property (
        (portDPullup & portDOutEn) == 8'h00) else $error("pull-up on driven pin");
    d_drive_a: assert property (
        dataWrite && !ioWrite && dataAddr == 16'h0032 ##1 !(ioWrite || dataWrite)
        |=> portDDrive == $past(dataWrData, 2)) else $error("port D drive not updated");
    e_drive_a: assert property (
        dataWrite && !ioWrite && dataAddr == 16'h0023 ##1 !(ioWrite || dataWrite)
        |=> portEDrive == $past(dataWrData, 2)) else $error("port E drive not updated");
    d_dir_a: assert property (
        ioWrite && ioAddr == 6'h11 ##1 !(ioWrite || dataWrite)
        |=> portDOutEn == $past(ioWrData, 2)) else $error("port D direction not updated");
    compat_low_a: assert property (
        compatMode [*7] |-> portCOutEn == 8'hFF && portCDrive == 8'h00)
        else $error("port C not driven low in compat mode");
    compat_preset_a: assert property (
        compatMode |-> portCOutEn == 8'hFF && portCDrive == 8'h00 && portCPullup == 8'h00)
        else $error("port C not preset low by compat strap");
endmodule // gpcde_port_regs_props

bind gpcde_port_regs gpcde_port_regs_props gpcde_port_regs_props_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .ioWrite(ioWrite), .ioAddr(ioAddr),
    .ioWrData(ioWrData), .dataRead(dataRead), .dataWrite(dataWrite), .dataAddr(dataAddr),
    .dataWrData(dataWrData), .dataRdData(dataRdData), .dataHit(dataHit),
    .compatMode(compatMode), .globalPullupOff(globalPullupOff), .portCDrive(portCDrive),
    .portCOutEn(portCOutEn), .portCPullup(portCPullup), .portDDrive(portDDrive),
    .portDOutEn(portDOutEn),
    .portDPullup(portDPullup), .portEDrive(portEDrive), .portEPullup(portEPullup));

// File: gpcde_pad_model.sv
// Pad model for ports C, D and E, port C in the low byte
`timescale 1ns/100ps
module gpcde_pad_model (
    // Pad controls from the slice
    input  wire [23:0] drive,
    input  wire [23:0] outEn,
    input  wire [23:0] pullEn,
    // Outside level and resolved pins
    input  wire [23:0] ext,
    output wire [23:0] pins
);
    // ==========
    // Pad resolution: the driver wins, a pull-up lifts an open input
    assign pins = (outEn & drive) | (~outEn & (pullEn | ext));
endmodule // gpcde_pad_model

// File: gpcde_port_regs_test.sv
// Self-checking bench for the port C/D/E register slice
`timescale 1ns/100ps
module gpcde_port_regs_test;
    reg         ref_clk = 1'b0;
    reg         rst_n = 1'b0;
    reg         ioRead = 1'b0;
    reg         ioWrite = 1'b0;
    reg  [5:0]  ioAddr = 6'h00;
    reg  [7:0]  ioWrData = 8'h00;
    reg         dataRead = 1'b0;
    reg         dataWrite = 1'b0;
    reg  [15:0] dataAddr = 16'h0000;
    reg  [7:0]  dataWrData = 8'h00;
    reg         compatMode = 1'b0;
    reg         globalPullupOff = 1'b0;
    reg  [23:0] ext = 24'h96C33C;
    wire [7:0]  ioRdData;
    wire [7:0]  dataRdData;
    wire        dataHit;
    wire [23:0] pins;
    wire [23:0] drv;
    wire [23:0] oen;
    wire [23:0] pu;
    int         num_errors = 0;
    int         n_compared = 0;
    // Sample offsets; direction and drive sit at +1 and +2
    reg  [5:0]  base [3] = '{6'h13, 6'h10, 6'h01};
    reg  [7:0]  dv [3] = '{8'h5A, 8'h7B, 8'h9C};
    reg  [7:0]  dr [3] = '{8'h0F, 8'h1E, 8'hF0};

    // ==========
    // Clock, slice and pads
    initial forever #20 ref_clk = ~ref_clk;
    gpcde_port_regs gpcde_port_regs_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .ioRead(ioRead), .ioWrite(ioWrite), .ioAddr(ioAddr), .ioWrData(ioWrData),
        .ioRdData(ioRdData), .dataRead(dataRead), .dataWrite(dataWrite),
        .dataAddr(dataAddr), .dataWrData(dataWrData), .dataRdData(dataRdData),
        .dataHit(dataHit), .compatMode(compatMode), .globalPullupOff(globalPullupOff),
        .portCPins(pins[7:0]), .portDPins(pins[15:8]), .portEPins(pins[23:16]),
        .portCDrive(drv[7:0]), .portCOutEn(oen[7:0]), .portCPullup(pu[7:0]),
        .portDDrive(drv[15:8]), .portDOutEn(oen[15:8]), .portDPullup(pu[15:8]),
        .portEDrive(drv[23:16]), .portEOutEn(oen[23:16]), .portEPullup(pu[23:16]));
    gpcde_pad_model gpcde_pad_model_i (.drive(drv), .outEn(oen), .pullEn(pu),
        .ext(ext), .pins(pins));

    // ==========
    // Compare, access tasks and expected pin level
    task automatic chk(input [15:0] got, input [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic ioAcc(input wr, input [5:0] a, input [7:0] d, input [7:0] exp);
        @(posedge ref_clk);
        ioWrite <= wr;
        ioRead <= ~wr;
        ioAddr <= a;
        ioWrData <= d;
        @(posedge ref_clk);
        ioWrite <= 1'b0;
        ioRead <= 1'b0;
        #1;
        if (!wr) chk({8'h00, ioRdData}, {8'h00, exp});
    endtask
    // Strobe held for exactly one edge; hit is checked on writes too
    task automatic dAcc(input wr, input [15:0] a, input [7:0] d, input [7:0] exp, input hit);
        @(posedge ref_clk);
        dataWrite <= wr;
        dataRead <= ~wr;
        dataAddr <= a;
        dataWrData <= d;
        @(posedge ref_clk);
        dataWrite <= 1'b0;
        dataRead <= 1'b0;
        #1;
        chk({7'h00, dataHit, wr ? 8'h00 : dataRdData}, {7'h00, hit, wr ? 8'h00 : exp});
    endtask
    function automatic [7:0] pinExp(input [7:0] d, input [7:0] v, input [7:0] e, input global_pullup_off);
        return (d & v) | (~d & ((v & {8{~global_pullup_off}}) | e));
    endfunction
    task automatic close_out;
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            ioAcc(1'b0, base[p] + 6'h1, 8'h00, 8'h00);
            dAcc(1'b0, 16'h0022 + base[p], 8'h00, 8'h00, 1'b1);
        end
        for (int p = 0; p < 3; p++) begin
            dAcc(1'b1, 16'h0022 + base[p], dv[p], 8'h00, 1'b1);
            ioAcc(1'b1, base[p] + 6'h1, dr[p], 8'h00);
            ioAcc(1'b0, base[p] + 6'h2, 8'h00, dv[p]);
            dAcc(1'b0, 16'h0021 + base[p], 8'h00, dr[p], 1'b1);
            ioAcc(1'b1, base[p], 8'hFF, 8'h00);
        end
        // Pin readback with pull-ups allowed, then globally off
        for (int u = 0; u < 2; u++) begin
            @(posedge ref_clk);
            globalPullupOff <= u[0];
            repeat (8) @(posedge ref_clk);
            for (int p = 0; p < 3; p++)
                ioAcc(1'b0, base[p], 8'h00, pinExp(dr[p], dv[p], ext[8*p +: 8], u[0]));
        end
        dAcc(1'b0, 16'h0073, 8'h00, 8'h00, 1'b0);
        dAcc(1'b1, 16'h0060, 8'hFF, 8'h00, 1'b0);
        dAcc(1'b0, 16'h0015, 8'h00, 8'h00, 1'b0);
        ioAcc(1'b0, 6'h3F, 8'h00, 8'h00);
        @(posedge ref_clk);
        compatMode <= 1'b1;
        #1;
        chk({oen[7:0], drv[7:0]}, 16'hFF00);
        repeat (8) @(posedge ref_clk);
        chk({oen[7:0], drv[7:0]}, 16'hFF00);
        ioAcc(1'b1, 6'h15, 8'hFF, 8'h00);
        repeat (4) @(posedge ref_clk);
        chk({oen[7:0], drv[7:0]}, 16'hFF00);
        close_out;
    end

    // Watchdog: the sequence needs well under 300 cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        num_errors++;
        close_out;
    end
endmodule // gpcde_port_regs_test
